//--- kpi_pkg.sv
// Constants, register map and field layout for the keypad pin interrupt block.
// Assumes an APB slave with 32-bit data; registers occupy aligned words.
// Notes on behaviour
// - Interrupt-enable bit 1 gates the request; zero means no request.
// - Mode bit 0 picks edge-only (0) or edge-and-level (1) detection.
// - Only pins with their enable bit set take part in detection.
// - Polarity bit 0 means falling/low, 1 rising/high; pins 5,4,2:0.
// - Falling edge: enabled input sampled 1 then 0 on consecutive cycles.
// - Rising edge: enabled input sampled 0 then 1 on consecutive cycles.
// - Edge needs the deasserted level seen first; sampled on bus clock.
// - Edge-only mode: valid edge on any enabled pin sets the sticky flag.
// - Edge-and-level mode: edge or asserted level sets the flag.
// - Flag set and interrupt enabled presents a request to the processor.
// - Edge-only mode: writing 1 to acknowledge clears the flag.
// - Level mode: acknowledge clears only if all enabled inputs deasserted.
// - Level mode: any enabled pin still asserted keeps the flag set.
// - Enabling a pin never turns on a pull device by itself.
// - A spurious flag at pin enable is cleared by normal acknowledge.
// - Enabled pin event with interrupt enabled wakes from stop and wait.
// - Writes to the flag bit are ignored.
// - The acknowledge bit always reads as zero.
// - In stop mode enabled pins are detected asynchronously for wake-up.
package kpi_pkg;

   localparam int         KPI_PINS        = 8;
   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] KPI_ADDR_SC     = 4'h0;
   localparam logic [3:0] KPI_ADDR_PE     = 4'h4;
   localparam logic [3:0] KPI_ADDR_ES     = 4'h8;
   // ------------------------------------------------------------
   // Status/control fields
   // ------------------------------------------------------------
   localparam int         KPI_SC_MODE     = 0;
   localparam int         KPI_SC_IE       = 1;
   localparam int         KPI_SC_ACK      = 2;
   localparam int         KPI_SC_FLAG     = 3;
   // Implemented pins 5,4,2:0
   localparam logic [7:0] KPI_PIN_MASK    = 8'h37;
   localparam logic [7:0] KPI_RESET_BYTE  = 8'h00;

endpackage : kpi_pkg

//--- kpi_sync.sv
// Two-flop synchroniser, one per pin.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module kpi_sync
   import kpi_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic [KPI_PINS-1:0] asyncIn,
   output logic      [KPI_PINS-1:0] syncOut
);
   logic [KPI_PINS-1:0] meta_q;
   logic [KPI_PINS-1:0] sync_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= asyncIn;
         sync_q <= meta_q;
      end
   end
   assign syncOut = sync_q;
endmodule : kpi_sync
`default_nettype wire

//--- kpi_detect.sv
// Per-pin assertion and transition detection after polarity correction.
// Assumes synchronised inputs on the same clock.
`timescale 1ns/1ps
`default_nettype none
module kpi_detect
   import kpi_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic [KPI_PINS-1:0] pinSync,
   input  wire logic [KPI_PINS-1:0] pinEnable,
   input  wire logic [KPI_PINS-1:0] polarity,
   output logic      [KPI_PINS-1:0] edgeHit,
   output logic      [KPI_PINS-1:0] levelHit
);
   logic [KPI_PINS-1:0] asserted;
   logic [KPI_PINS-1:0] hist_q;
   logic [KPI_PINS-1:0] hist_d;

   genvar i;
   generate
      for (i = 0; i < KPI_PINS; i++) begin : g_pin
         // Active level normalised to 1
         assign asserted[i] = pinSync[i] ~^ polarity[i];
         // History forced to asserted while disabled so enabling needs a deasserted sample first
         assign hist_d[i]   = pinEnable[i] ? asserted[i] : 1'b1;
         assign edgeHit[i]  = pinEnable[i] & ~hist_q[i] & asserted[i];
         assign levelHit[i] = pinEnable[i] & asserted[i];
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hist_q <= '1;
      end else begin
         hist_q <= hist_d;
      end
   end
endmodule : kpi_detect
`default_nettype wire

//--- kpi_top.sv
// Keypad pin interrupt: APB registers, sticky flag, request and wake outputs.
// Assumes pins are asynchronous; pull devices live in the port logic.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module kpi_top
   import kpi_pkg::*;
(
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [KPI_PINS-1:0] key_input_pin_n,
   output logic                     irqRequest,
   output logic                     wakeRequest
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic                irq_request_enable_q, irq_request_enable_d;
   logic                detect_mode_select_q, detect_mode_select_d;
   logic                key_event_flag_q,     key_event_flag_d;
   logic [7:0]          pin_enable_q,         pin_enable_d;
   logic [7:0]          polarity_select_q,    polarity_select_d;
   logic [31:0]         prdata_q,             prdata_d;
   logic                pslverr_q,            pslverr_d;
   logic [KPI_PINS-1:0] pinSync;
   logic [KPI_PINS-1:0] edgeHit;
   logic [KPI_PINS-1:0] levelHit;
   logic                access;
   logic                wrAccess;
   logic                mapped;
   logic                ackWrite;
   logic                setEvent;
   logic                anyAsserted;
   logic [7:0]          scByte;
   logic                waited_q;
   logic                waited_d;

   kpi_sync u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .asyncIn (key_input_pin_n),
      .syncOut (pinSync)
   );

   kpi_detect u_detect (
      .clock     (clock),
      .rst_n     (rst_n),
      .pinSync   (pinSync),
      .pinEnable (pin_enable_q),
      .polarity  (polarity_select_q),
      .edgeHit   (edgeHit),
      .levelHit  (levelHit)
   );

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Writes land only on the completing edge, so an acknowledge acts once
   assign access   = psel & penable;
   assign wrAccess = access & waited_q & pwrite & pstrb[0];
   assign mapped   = (paddr[31:4] == 28'h0000000) & (paddr[1:0] == 2'h0) &
                     ((paddr[3:0] == KPI_ADDR_SC) | (paddr[3:0] == KPI_ADDR_PE) |
                      (paddr[3:0] == KPI_ADDR_ES));
   assign ackWrite = wrAccess & mapped & (paddr[3:0] == KPI_ADDR_SC) &
                     pwdata[KPI_SC_ACK];

   // ------------------------------------------------------------
   // Detection and flag
   // ------------------------------------------------------------
   assign anyAsserted = |levelHit;
   always_comb begin
      setEvent = |edgeHit;
      if (detect_mode_select_q) begin
         setEvent = (|edgeHit) | anyAsserted;
      end
   end

   always_comb begin
      key_event_flag_d = key_event_flag_q;
      // Clear only where allowed; level mode refuses it while a pin is asserted
      if (ackWrite && !(detect_mode_select_q && anyAsserted)) begin
         key_event_flag_d = 1'b0;
      end
      // A new event in the acknowledge cycle wins over the clear
      if (setEvent) begin
         key_event_flag_d = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_comb begin
      irq_request_enable_d = irq_request_enable_q;
      detect_mode_select_d = detect_mode_select_q;
      pin_enable_d         = pin_enable_q;
      polarity_select_d    = polarity_select_q;
      if (wrAccess && mapped) begin
         case (paddr[3:0])
            KPI_ADDR_SC: begin
               // Flag bit write ignored; it has no path from pwdata
               irq_request_enable_d = pwdata[KPI_SC_IE];
               detect_mode_select_d = pwdata[KPI_SC_MODE];
            end
            // Pull devices are not touched here
            KPI_ADDR_PE: pin_enable_d      = pwdata[7:0] & KPI_PIN_MASK;
            KPI_ADDR_ES: polarity_select_d = pwdata[7:0] & KPI_PIN_MASK;
            default:     pin_enable_d      = pin_enable_q;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   always_comb begin
      scByte              = 8'h00;
      scByte[KPI_SC_FLAG] = key_event_flag_q;
      scByte[KPI_SC_IE]   = irq_request_enable_q;
      scByte[KPI_SC_MODE] = detect_mode_select_q;
      // Acknowledge bit stays zero on read
      scByte[KPI_SC_ACK]  = 1'b0;
      prdata_d  = prdata_q;
      pslverr_d = 1'b0;
      if (access) begin
         pslverr_d = ~mapped;
         case (paddr[3:0])
            KPI_ADDR_SC: prdata_d = {24'h000000, scByte};
            KPI_ADDR_PE: prdata_d = {24'h000000, pin_enable_q};
            KPI_ADDR_ES: prdata_d = {24'h000000, polarity_select_q};
            default:     prdata_d = 32'h00000000;
         endcase
         if (!mapped || pwrite) begin
            prdata_d = 32'h00000000;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_request_enable_q <= 1'b0;
         detect_mode_select_q <= 1'b0;
         key_event_flag_q     <= 1'b0;
         pin_enable_q         <= KPI_RESET_BYTE;
         polarity_select_q    <= KPI_RESET_BYTE;
         prdata_q             <= 32'h00000000;
         pslverr_q            <= 1'b0;
      end else begin
         irq_request_enable_q <= irq_request_enable_d;
         detect_mode_select_q <= detect_mode_select_d;
         key_event_flag_q     <= key_event_flag_d;
         pin_enable_q         <= pin_enable_d;
         polarity_select_q    <= polarity_select_d;
         prdata_q             <= prdata_d;
         pslverr_q            <= pslverr_d;
      end
   end

   // Registered read data is valid the cycle after the access is sampled,
   // so the slave inserts one wait state on every access.
   always_comb begin
      waited_d = access & ~waited_q;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         waited_q <= 1'b0;
      end else begin
         waited_q <= waited_d;
      end
   end
   assign pready  = waited_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q & waited_q;

   // ------------------------------------------------------------
   // Request and wake
   // ------------------------------------------------------------
   assign irqRequest  = key_event_flag_q & irq_request_enable_q;
   // Wake needs no clock: raw pin path, so it works with the bus clock stopped
   always_comb begin
      wakeRequest = key_event_flag_q & irq_request_enable_q;
      for (int k = 0; k < KPI_PINS; k++) begin
         if (pin_enable_q[k] && irq_request_enable_q &&
             (key_input_pin_n[k] == polarity_select_q[k])) begin
            wakeRequest = 1'b1;
         end
      end
   end
endmodule : kpi_top
`default_nettype wire

//--- kpi_top_assertions.sv
// Port checker for kpi_top, bound at the foot.
// Assumes an APB master that keeps psel/penable order.
`timescale 1ns/1ps
`default_nettype none
module kpi_top_assertions
   import kpi_pkg::*;
(
   input wire logic                clock,
   input wire logic                rst_n,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [31:0]         paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [3:0]          pstrb,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic [KPI_PINS-1:0] key_input_pin_n,
   input wire logic                irqRequest,
   input wire logic                wakeRequest
);
   logic ieQ;
   logic ieD;
   logic wrSc;
   logic rdOk;
   // Shadow of the enable bit, taken on the completing access edge
   assign wrSc = psel & penable & pwrite & pready & pstrb[0] & (paddr == 32'h0);
   assign rdOk = pready & ~pwrite;
   always_comb ieD = wrSc ? pwdata[KPI_SC_IE] : ieQ;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) ieQ <= 1'b0;
      else ieQ <= ieD;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_IRQ_GATED: assert property (irqRequest |-> ieQ)
      else $error("request without enable");
   AST_WAKE_GATED: assert property (!ieQ |-> !wakeRequest)
      else $error("wake without enable");
   AST_IRQ_WAKES: assert property (irqRequest |-> wakeRequest)
      else $error("request without wake");
   AST_IRQ_STICKY: assert property ($fell(irqRequest) |-> $past(wrSc))
      else $error("request fell without a write");
   AST_ACK_READS_ZERO: assert property (rdOk && paddr == 32'h0 |-> !prdata[KPI_SC_ACK])
      else $error("ack bit read as one");
   AST_PIN_MASK: assert property (rdOk && paddr inside {32'h4, 32'h8}
      |-> prdata == {24'h0, prdata[7:0] & KPI_PIN_MASK})
      else $error("unimplemented pin bit set");
   AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("access not one wait state");
   AST_MAPPED_OK: assert property (pready && paddr inside {32'h0, 32'h4, 32'h8} |-> !pslverr)
      else $error("error on mapped register");
endmodule : kpi_top_assertions
bind kpi_top kpi_top_assertions kpi_top_assertions_i (.clock(clock), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .key_input_pin_n(key_input_pin_n), .irqRequest(irqRequest), .wakeRequest(wakeRequest));
`default_nettype wire

//--- kpi_key_model.sv
// Key switch model: a pin rests at its pull level, a press drives the other.
// Assumes the pull level comes from port logic, never from the block.
`timescale 1ns/1ps
`default_nettype none
module kpi_key_model
   import kpi_pkg::*;
(
   input  wire logic [KPI_PINS-1:0] pressed,
   input  wire logic [KPI_PINS-1:0] pullHigh,
   output logic      [KPI_PINS-1:0] keyPins
);
   // Pull set by the port side alone, so enabling a pin changes nothing here
   assign keyPins = pullHigh ^ pressed;
endmodule : kpi_key_model
`default_nettype wire

//--- tb_kpi_top.sv
// Self-checking bench for kpi_top with the key switch model.
// Assumes one clock and one APB wait state per access.
`timescale 1ns/1ps
`default_nettype none
module tb_kpi_top
   import kpi_pkg::*;
;
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, irqRequest, wakeRequest, errQ;
   logic [31:0] paddr, pwdata, prdata, rdData;
   logic [3:0]  pstrb;
   logic [KPI_PINS-1:0] keyPins, pressed, pullHigh;
   int err_total, checks_done;
   kpi_top kpi_top_i (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .key_input_pin_n(keyPins),
      .irqRequest(irqRequest), .wakeRequest(wakeRequest));
   kpi_key_model kpi_key_model_i (.pressed(pressed), .pullHigh(pullHigh), .keyPins(keyPins));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic apb(int wr, logic [31:0] addr, logic [31:0] wd);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr[0];
      paddr <= addr;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++)
         @(posedge clock);
      if (n == 20) begin
         err_total++;
         final_report();
      end
      rdData = prdata;
      errQ = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic waitIrq(int exp);
      int n;
      repeat (6) @(posedge clock);
      for (n = 0; n < 12 && irqRequest !== exp[0]; n++)
         @(posedge clock);
      chk("irqRequest", {31'h0, irqRequest}, {31'h0, exp[0]});
   endtask : waitIrq
   task automatic sResetMap;
      apb(0, 32'h0, 0); chk("sc", rdData, 0);
      apb(0, 32'h4, 0); chk("pe", rdData, 0);
      apb(0, 32'h8, 0); chk("es", rdData, 0);
      apb(0, 32'hc, 0); chk("slverr", {31'h0, errQ}, 1);
      apb(1, 32'h4, 32'hff); apb(0, 32'h4, 0); chk("pe mask", rdData, 32'h37);
      // Pin 1 rests low and is enabled while asserted: no edge may follow
      apb(0, 32'h0, 0); chk("sc", rdData, 0);
   endtask : sResetMap
   task automatic sEdgeFall;
      apb(1, 32'h0, 0); apb(1, 32'h8, 0); apb(1, 32'h4, 32'h31);
      apb(1, 32'h0, 32'h4); apb(1, 32'h0, 32'h2);
      pressed <= 8'h04;
      waitIrq(0);
      pressed <= 8'h01;
      waitIrq(1);
      apb(0, 32'h0, 0); chk("sc", rdData, 32'h0a);
      apb(1, 32'h0, 32'h2);
      waitIrq(1);
      apb(1, 32'h0, 32'h6);
      waitIrq(0);
      // Flag clear but pin 0 still held low: raw wake path alone
      chk("wake", {31'h0, wakeRequest}, 1);
      pressed <= 8'h00;
      apb(1, 32'h0, 32'h0a); apb(0, 32'h0, 0); chk("sc", rdData, 32'h02);
      chk("wake", {31'h0, wakeRequest}, 0);
   endtask : sEdgeFall
   task automatic sLevel;
      apb(1, 32'h0, 32'h3);
      pressed <= 8'h10;
      waitIrq(1);
      apb(1, 32'h0, 32'h7); apb(0, 32'h0, 0); chk("sc", rdData, 32'h0b);
      pressed <= 8'h00;
      // Let the release pass both sync flops before acknowledging
      repeat (4) @(posedge clock);
      apb(1, 32'h0, 32'h7);
      waitIrq(0);
   endtask : sLevel
   task automatic sRiseGate;
      apb(1, 32'h0, 0); apb(1, 32'h8, 32'h2); apb(1, 32'h4, 32'h2); apb(1, 32'h0, 32'h4);
      pressed <= 8'h02;
      waitIrq(0);
      chk("wake", {31'h0, wakeRequest}, 0);
      apb(0, 32'h0, 0); chk("sc", rdData, 32'h08);
      apb(1, 32'h0, 32'h2);
      waitIrq(1);
      chk("wake", {31'h0, wakeRequest}, 1);
      pressed <= 8'h00;
      apb(1, 32'h0, 32'h6);
      waitIrq(0);
   endtask : sRiseGate
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      pstrb = 4'hf;
      pressed = 8'h00;
      // Pin 1 rests low for the rising case
      pullHigh = 8'hfd;
      err_total = 0;
      checks_done = 0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      sResetMap();
      sEdgeFall();
      sLevel();
      sRiseGate();
      final_report();
   end
endmodule : tb_kpi_top
`default_nettype wire
